/* File: rtl/pin_sync.sv */
// pin_sync: two-stage synchroniser for a group of asynchronous pin levels.
// assumes the inputs are slow levels; pulses shorter than a clock may be lost.
`timescale 1ns/100ps

module pin_sync #(
  parameter int         WIDTH     = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  // asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_r;   // first stage, read only by the second

  initial begin
    if (WIDTH < 1) begin
      $error("pin_sync: WIDTH must be at least 1");
    end
  end

  // two flops in a row; the first is never looked at by any other logic
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      meta_r <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta_r <= pin_i;
      sync_o <= meta_r;
    end
  end

endmodule : pin_sync

/* File: rtl/reset_strap_boot_select.sv */
// reset_strap_boot_select: samples jtag straps during a pin reset to pick pll
// bypass and boot rom mapping, keeps the software boot-enable bit and maps the
// 256-word boot rom over program addresses 0000h..00FFh.
// assumes pins are asynchronous (synchronised here) and software access to the
// boot-enable bit arrives as a same-clock write strobe with data.
`timescale 1ns/100ps

module reset_strap_boot_select #(
  parameter logic [strap_pkg::BOOT_WORDS-1:0][strap_pkg::WORD_W-1:0] BOOT_IMAGE = '0
) (
  // clock and block reset
  input  wire logic                              clk_sys_i,
  input  wire logic                              rst_i,
  // device pins, asynchronous
  input  wire logic                              device_reset_pin_n_i,
  input  wire logic                              jtag_tms_i,
  input  wire logic                              jtag_trst_n_i,
  input  wire logic                              jtag_tdi_i,
  input  wire logic                              power_drive_protect_input_n_i,
  // software access to system_control_reg2 boot-enable bit
  input  wire logic                              boot_en_wr_i,
  input  wire logic                              boot_en_wdata_i,
  output logic                                   boot_en_bit_o,
  // program-space fetch
  input  wire logic                              prog_rd_i,
  input  wire logic [strap_pkg::PROG_ADDR_W-1:0] prog_addr_i,
  output logic                                   boot_rom_sel_o,
  output logic                                   flash_sel_o,
  output logic      [strap_pkg::WORD_W-1:0]      boot_rom_data_o,
  // clock control and status
  output logic                                   pll_bypass_o,
  output logic                                   device_in_reset_o,
  output logic                                   boot_strap_o,
  output logic                                   loader_pdp_fault_o
);

  // synchronised pin levels
  logic                         rst_pin_n_s;
  logic                         tms_s;
  logic                         trst_n_s;
  logic                         tdi_s;
  logic                         pdp_n_s;

  // state
  strap_pkg::reset_phase_type   phase_r;
  strap_pkg::reset_phase_type   phase_nxt;
  logic                         pll_bypass_r;
  logic                         pll_bypass_nxt;
  logic                         boot_en_r;
  logic                         boot_en_nxt;
  logic [strap_pkg::WORD_W-1:0] rom_data_r;
  logic                         pdp_fault_r;

  // decode wires
  logic                         reset_held;
  logic                         strap_bypass;
  logic                         boot_cond;
  logic                         tdi_trst_low;
  logic                         in_boot_range;
  logic                         rom_mapped;
  logic                         rom_hit;
  logic [strap_pkg::BOOT_IDX_W-1:0] rom_idx;

  // elaboration check: the rom window must match the index width
  initial begin
    if (strap_pkg::BOOT_WORDS != (1 << strap_pkg::BOOT_IDX_W)) begin
      $error("reset_strap_boot_select: boot rom size and index width disagree");
    end
    if (strap_pkg::BOOT_LAST - strap_pkg::BOOT_BASE + 1 != strap_pkg::BOOT_WORDS) begin
      $error("reset_strap_boot_select: boot window does not span the rom");
    end
  end

  // pins come from the board and the emulator pod, so all of them are
  // synchronised; reset pin starts as asserted so straps are sampled first
  pin_sync #(
    .WIDTH   (5),
    .RST_VAL (5'h1E)
  ) u_pin_sync (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .pin_i     ({power_drive_protect_input_n_i, jtag_trst_n_i, jtag_tms_i,
                 jtag_tdi_i, device_reset_pin_n_i}),
    .sync_o    ({pdp_n_s, trst_n_s, tms_s, tdi_s, rst_pin_n_s})
  );

  // strap decode
  assign reset_held    = ~rst_pin_n_s;
  assign strap_bypass  = ~tms_s & ~trst_n_s;
  assign boot_cond     = ~trst_n_s & ~rst_pin_n_s & ~tdi_s;
  assign tdi_trst_low  = ~tdi_s & ~trst_n_s;

  // reset phase tracking: held while the pin is low, run once released
  always_comb begin
    phase_nxt = phase_r;
    case (phase_r)
      strap_pkg::PHASE_IDLE: begin
        if (reset_held) begin
          phase_nxt = strap_pkg::PHASE_HELD;
        end
      end
      strap_pkg::PHASE_HELD: begin
        if (!reset_held) begin
          phase_nxt = strap_pkg::PHASE_RUN;
        end
      end
      strap_pkg::PHASE_RUN: begin
        if (reset_held) begin
          phase_nxt = strap_pkg::PHASE_HELD;
        end
      end
      default: begin
        phase_nxt = strap_pkg::PHASE_IDLE;
      end
    endcase
  end

  // pll bypass follows the straps only while the pin reset is held, so the
  // choice freezes at release and a later reset can undo it
  always_comb begin
    pll_bypass_nxt = pll_bypass_r;
    if (reset_held) begin
      pll_bypass_nxt = strap_bypass;
    end
  end

  // boot-enable bit: strapped during reset, software may rewrite it after.
  // writes during a pin reset are dropped since the straps own the bit then
  always_comb begin
    boot_en_nxt = boot_en_r;
    if (reset_held) begin
      // mapping decided by condition at reset
      if (boot_cond && tdi_trst_low) begin
        boot_en_nxt = strap_pkg::BOOT_EN_ON;
      end else begin
        boot_en_nxt = strap_pkg::BOOT_EN_OFF;
      end
    end else if (boot_en_wr_i) begin
      boot_en_nxt = boot_en_wdata_i;
    end
  end

  // state registers
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      phase_r      <= strap_pkg::PHASE_IDLE;
      pll_bypass_r <= strap_pkg::PLL_BYPASS_RST;
      boot_en_r    <= strap_pkg::BOOT_EN_OFF;
    end else begin
      phase_r      <= phase_nxt;
      pll_bypass_r <= pll_bypass_nxt;
      boot_en_r    <= boot_en_nxt;
    end
  end

  // program-space window decode; the rom is never selected during a pin reset
  assign in_boot_range = (prog_addr_i >= strap_pkg::BOOT_BASE) &&
                         (prog_addr_i <= strap_pkg::BOOT_LAST);
  assign rom_mapped    = (boot_en_r == strap_pkg::BOOT_EN_ON) && !reset_held;
  assign rom_hit       = prog_rd_i && in_boot_range && rom_mapped;
  assign rom_idx       = prog_addr_i[strap_pkg::BOOT_IDX_W-1:0];

  // bit at 1 routes window to flash
  assign boot_rom_sel_o = rom_hit;
  assign flash_sel_o    = prog_rd_i && !rom_hit && !reset_held;

  // rom read: data appears one clock after a selected fetch and then holds
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rom_data_r <= '0;
    end else if (rom_hit) begin
      rom_data_r <= BOOT_IMAGE[rom_idx];
    end
  end

  // loader guard: a low power-drive-protect level while the rom is being
  // fetched would let a shutdown interrupt hit the loader; flag it sticky.
  // a new event wins over the clear that a pin reset brings
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pdp_fault_r <= 1'h0;
    end else if (rom_hit && !pdp_n_s) begin
      // watch the protect input while loading
      pdp_fault_r <= 1'h1;
    end else if (reset_held) begin
      pdp_fault_r <= 1'h0;
    end
  end

  // outputs
  assign pll_bypass_o       = pll_bypass_r;
  assign boot_en_bit_o      = boot_en_r;
  assign boot_rom_data_o    = rom_data_r;
  assign device_in_reset_o  = (phase_r != strap_pkg::PHASE_RUN);
  assign boot_strap_o       = boot_cond;
  assign loader_pdp_fault_o = pdp_fault_r;

  // a reset pulse with new straps clears a bypass left by the debugger
  // nothing extra: reset_held re-samples the straps as shown above

endmodule : reset_strap_boot_select

/* File: rtl/strap_pkg.sv */
// strap_pkg: constants for the reset-time strap and boot-select logic.
// assumes one system clock; every pin strap reaches the logic through a synchroniser.
package strap_pkg;

  // program-space geometry of the boot rom window
  localparam int          PROG_ADDR_W   = 16;
  localparam int          BOOT_WORDS    = 256;
  localparam int          BOOT_IDX_W    = 8;
  localparam int          WORD_W        = 16;
  localparam logic [15:0] BOOT_BASE     = 16'h0000;
  localparam logic [15:0] BOOT_LAST     = 16'h00FF;

  // boot-enable bit of system_control_reg2, active low (0 = boot rom mapped)
  localparam int          BOOT_EN_BIT   = 3;
  localparam logic        BOOT_EN_ON    = 1'h0;
  localparam logic        BOOT_EN_OFF   = 1'h1;

  // pll state after the block-level reset, before any pin reset is seen
  localparam logic        PLL_BYPASS_RST = 1'h0;

  // synchroniser depth for pin inputs
  localparam int          SYNC_STAGES   = 2;

  // phase of the device reset pin as seen by the strap logic
  typedef enum logic [1:0] {
    PHASE_IDLE    = 2'b00,
    PHASE_HELD    = 2'b01,
    PHASE_RUN     = 2'b10
  } reset_phase_type;

endpackage : strap_pkg

/* File: testbench/board_pod_model.sv */
// board_pod_model: board reset source plus optional jtag pod on the strap pins.
// assumes the bench calls hold and release_pin one at a time, in that order.
`timescale 1ns/100ps
module board_pod_model (
  // clock
  input wire logic clk_sys_i,
  // pins toward the device
  output logic     reset_pin_n_o,
  output logic     tms_o,
  output logic     trst_n_o,
  output logic     tdi_o,
  output logic     pdp_n_o
);
  // protect input high
  // power-up: reset held, test-reset pulled down, protect never pulled low
  initial begin
    reset_pin_n_o = 1'h0;
    tms_o = 1'h0;
    trst_n_o = 1'h0;
    tdi_o = 1'h0;
    pdp_n_o = 1'h1;
  end
  // assert device reset and set the straps
  // a new reset with new straps is how the debugger leaves bypass
  task automatic hold(input logic tms, input logic trst_n, input logic tdi);
    @(posedge clk_sys_i);
    reset_pin_n_o <= 1'h0;
    tms_o <= tms;
    trst_n_o <= trst_n;
    tdi_o <= tdi;
  endtask : hold
  // tms and tdi wander one cycle after release, as a live pod does
  task automatic release_pin();
    @(posedge clk_sys_i);
    reset_pin_n_o <= 1'h1;
    @(posedge clk_sys_i);
    tms_o <= ~tms_o;
    tdi_o <= ~tdi_o;
  endtask : release_pin
endmodule : board_pod_model

/* File: testbench/reset_strap_boot_select_tb.sv */
// reset_strap_boot_select_tb: every strap code, fetches and boot writes, queued checks.
// assumes board_pod_model drives the pins and strap_monitor is bound to the design.
`timescale 1ns/100ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin err_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module reset_strap_boot_select_tb;
  typedef logic [strap_pkg::BOOT_WORDS-1:0][strap_pkg::WORD_W-1:0] image_type;
  logic        clk_sys_i = 1'h0;
  logic        rst_i = 1'h1;
  logic        boot_en_wr_i = 1'h0;
  logic        boot_en_wdata_i = 1'h0;
  logic        prog_rd_i = 1'h0;
  logic [15:0] prog_addr_i = 16'h0000;
  logic        pin_n, tms, trst_n, tdi, pdp_n;
  logic        bit_o, rom_sel, flash_sel, pll_o, in_rst, strap_o, fault_o;
  logic [15:0] data_o;
  logic [21:0] note_q[$];
  logic [21:0] n;
  logic [15:0] data_exp;
  logic        data_pend = 1'h0;
  logic        exp_pll, exp_bit, exp_rst, exp_strap;
  logic [31:0] seed = 32'h9E357806;
  int          err_count = 0;
  int          comparisons = 0;
  // rom word i is A5 followed by its index, so a wrong index shows at once
  function automatic image_type make_image();
    image_type m;
    for (int i = 0; i < strap_pkg::BOOT_WORDS; i++) m[i] = {8'hA5, i[7:0]};
    return m;
  endfunction : make_image
  localparam image_type IMAGE = make_image();
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  reset_strap_boot_select #(.BOOT_IMAGE(IMAGE)) reset_strap_boot_select_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .device_reset_pin_n_i(pin_n), .jtag_tms_i(tms),
    .jtag_trst_n_i(trst_n), .jtag_tdi_i(tdi), .power_drive_protect_input_n_i(pdp_n),
    .boot_en_wr_i(boot_en_wr_i), .boot_en_wdata_i(boot_en_wdata_i), .boot_en_bit_o(bit_o),
    .prog_rd_i(prog_rd_i), .prog_addr_i(prog_addr_i), .boot_rom_sel_o(rom_sel),
    .flash_sel_o(flash_sel), .boot_rom_data_o(data_o), .pll_bypass_o(pll_o),
    .device_in_reset_o(in_rst), .boot_strap_o(strap_o), .loader_pdp_fault_o(fault_o));
  board_pod_model board_pod_model_inst (.clk_sys_i(clk_sys_i), .reset_pin_n_o(pin_n),
    .tms_o(tms), .trst_n_o(trst_n), .tdi_o(tdi), .pdp_n_o(pdp_n));
  always #25 clk_sys_i = ~clk_sys_i;
  task automatic end_of_test();
    if (err_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  // a fetch notes the whole expected status; rom selected only off reset, low page, bit 0
  task automatic fetch(input logic [15:0] a);
    logic sel;
    @(posedge clk_sys_i);
    prog_rd_i <= 1'h1;
    boot_en_wr_i <= 1'h0;
    prog_addr_i <= a;
    sel = !exp_rst && a[15:8] == 8'h00 && !exp_bit;
    note_q.push_back({exp_pll, exp_bit, exp_rst, exp_strap, sel, !exp_rst && !sel, 8'hA5, a[7:0]});
  endtask : fetch
  // writes while the pin reset is held are dropped, so the note stays
  task automatic write(input logic d);
    @(posedge clk_sys_i);
    boot_en_wr_i <= 1'h1;
    prog_rd_i <= 1'h0;
    boot_en_wdata_i <= d;
    if (!exp_rst) exp_bit = d;
  endtask : write
  task automatic idle();
    @(posedge clk_sys_i);
    prog_rd_i <= 1'h0;
    boot_en_wr_i <= 1'h0;
  endtask : idle
  // each fetch cycle takes the oldest note; the rom word is checked one cycle later
  always @(negedge clk_sys_i) begin
    if (data_pend) `CHK(data_o, data_exp)
    data_pend = 1'h0;
    if (prog_rd_i === 1'h1) begin
      n = note_q.pop_front();
      `CHK({pll_o, bit_o, in_rst, strap_o}, n[21:18])
      `CHK({rom_sel, flash_sel}, n[17:16])
      data_pend = n[17];
      data_exp = n[15:0];
    end
  end
  initial begin
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    for (int c = 0; c < 8; c++) begin
      board_pod_model_inst.hold(c[2], c[1], c[0]);
      repeat (5) @(posedge clk_sys_i);
      exp_pll = !c[2] && !c[1];
      exp_bit = c[1] || c[0];
      exp_rst = 1'h1;
      exp_strap = !exp_bit;
      write(!exp_bit);
      fetch(16'h0010);
      idle();
      board_pod_model_inst.release_pin();
      repeat (3) @(posedge clk_sys_i);
      exp_rst = 1'h0;
      exp_strap = 1'h0;
      fetch(16'h0000);
      fetch(16'h00FF);
      fetch(16'h0100);
      seed = xs(seed);
      fetch({seed[8] ? 8'h00 : seed[31:24], seed[7:0]});
      write(1'h0);
      write(1'h1);
      write(1'h0);
      fetch(16'h0080);
      write(1'h1);
      fetch(16'h0080);
      idle();
    end
    repeat (2) @(posedge clk_sys_i);
    `CHK(fault_o, 1'h0)
    end_of_test();
  end
  // the run needs about 220 cycles; 4000 cycles, about eighteen times that, means a hang
  initial begin
    #(50 * 4000);
    err_count++;
    end_of_test();
  end
endmodule : reset_strap_boot_select_tb

/* File: testbench/strap_monitor.sv */
// strap_monitor: port assertions for the strap, boot-select and fetch logic.
// assumes one clock, rst_i as the only disable, pins seen through a 2-stage sync.
`timescale 1ns/100ps
module strap_monitor #(
  parameter logic [strap_pkg::BOOT_WORDS-1:0][strap_pkg::WORD_W-1:0] BOOT_IMAGE = '0
) (
  // clock and reset
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  // pins and requests
  input wire logic        device_reset_pin_n_i,
  input wire logic        jtag_tms_i,
  input wire logic        jtag_trst_n_i,
  input wire logic        jtag_tdi_i,
  input wire logic        boot_en_wr_i,
  input wire logic        boot_en_wdata_i,
  input wire logic        prog_rd_i,
  input wire logic [15:0] prog_addr_i,
  // answers
  input wire logic        boot_en_bit_o,
  input wire logic        boot_rom_sel_o,
  input wire logic        flash_sel_o,
  input wire logic [15:0] boot_rom_data_o,
  input wire logic        pll_bypass_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic [7:0] idx_r;
  // fetch index kept for the data check one cycle later
  always_ff @(posedge clk_sys_i) idx_r <= prog_addr_i[7:0];
  // margins of 3..5 cycles cover the sync latency plus the strap register
  bypass_pick_a: assert property (
    (!device_reset_pin_n_i && $stable({jtag_tms_i, jtag_trst_n_i}))[*5]
    |-> pll_bypass_o == (!jtag_tms_i && !jtag_trst_n_i)) else $error("pll bypass wrong");
  bypass_hold_a: assert property (device_reset_pin_n_i[*4] |=> $stable(pll_bypass_o))
    else $error("pll bypass moved");
  boot_strap_a: assert property (
    (!device_reset_pin_n_i && $stable({jtag_trst_n_i, jtag_tdi_i}))[*5]
    |-> boot_en_bit_o == (jtag_trst_n_i || jtag_tdi_i)) else $error("boot bit wrong");
  boot_write_a: assert property (device_reset_pin_n_i[*3] ##0 boot_en_wr_i
    |=> boot_en_bit_o == $past(boot_en_wdata_i)) else $error("boot write lost");
  rom_window_a: assert property (device_reset_pin_n_i[*4] ##0 prog_rd_i
    |-> boot_rom_sel_o == (prog_addr_i[15:8] == 8'h00 && !boot_en_bit_o))
    else $error("rom select wrong");
  flash_path_a: assert property (device_reset_pin_n_i[*4] ##0 prog_rd_i
    |-> flash_sel_o != boot_rom_sel_o) else $error("flash select wrong");
  reset_quiet_a: assert property ((!device_reset_pin_n_i)[*4]
    |-> !boot_rom_sel_o && !flash_sel_o) else $error("select during reset");
  rom_data_a: assert property (boot_rom_sel_o |=> boot_rom_data_o == BOOT_IMAGE[idx_r])
    else $error("rom word wrong");
  cover property (boot_rom_sel_o);
  cover property ($rose(pll_bypass_o));
  cover property (boot_en_wr_i && !boot_en_wdata_i && jtag_trst_n_i);
endmodule : strap_monitor
bind reset_strap_boot_select strap_monitor #(.BOOT_IMAGE(BOOT_IMAGE)) strap_monitor_inst (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .device_reset_pin_n_i(device_reset_pin_n_i),
  .jtag_tms_i(jtag_tms_i), .jtag_trst_n_i(jtag_trst_n_i), .jtag_tdi_i(jtag_tdi_i),
  .boot_en_wr_i(boot_en_wr_i), .boot_en_wdata_i(boot_en_wdata_i), .prog_rd_i(prog_rd_i),
  .prog_addr_i(prog_addr_i), .boot_en_bit_o(boot_en_bit_o), .boot_rom_sel_o(boot_rom_sel_o),
  .flash_sel_o(flash_sel_o), .boot_rom_data_o(boot_rom_data_o), .pll_bypass_o(pll_bypass_o));
